// file: hdl/pmb_decode_map.vh
`ifndef PMB_DECODE_MAP_VH
`define PMB_DECODE_MAP_VH
`define PMB_OR_STATUS_OPCODE 16'h007C
`define PMB_MOVES_OP_HI 8'h0E
`define PMB_MMU_BR_OP_HI 9'h1E1
`define PMB_BR_SIZE_BIT 6
`define PMB_SIZE_BYTE 2'b00
`define PMB_SIZE_WORD 2'b01
`define PMB_SIZE_LONG 2'b10
`define PMB_MODE_IND 3'b010
`define PMB_MODE_IDX 3'b110
`define PMB_MODE_ABS 3'b111
`define PMB_REG_ABS_W 3'b000
`define PMB_REG_ABS_L 3'b001
`define PMB_FC_UDATA 3'h1
`define PMB_FC_UPROG 3'h2
`define PMB_FC_SDATA 3'h5
`define PMB_FC_SPROG 3'h6
`define PMB_STATUS_SUPER_BIT 13
`define PMB_STATUS_RESET 16'h2700
`define PMB_PC_RESET 32'h00000000
`endif

// file: hdl/pmb_decode.v
`include "pmb_decode_map.vh"
`default_nettype none
// What this block does
// RULE_01 - size field 00 byte, 01 word, 10 long for alternate-space move
// RULE_02 - only memory-alterable addressing modes accepted, others rejected
// RULE_03 - register-type bit picks data (0) or address (1) register, field gives number
// RULE_04 - direction bit 0 loads general register, 1 stores it to memory
// RULE_05 - source equal to incremented base stores the already updated value
// RULE_06 - merged-space: instruction space codes 6/2 become data codes 5/1
// RULE_07 - faulted converted access records converted code in transfer modifier field
// RULE_08 - software invalidates instruction cache line before instruction-space writes
// RULE_09 - OR to status only in supervisor state, else privilege trap
// RULE_10 - immediate word ORed into status word and written back
// RULE_11 - immediate bits 4..0 set extend, negative, zero, overflow, carry
// RULE_12 - mmu branch: taken loads pc plus displacement, else fall through; user traps
// RULE_13 - displacement is byte distance from address of first displacement word
// RULE_14 - displacement is one word or two words, most significant first
// RULE_15 - condition codes: even set conditions 0..14, odd clear conditions up to 15
// RULE_16 - the mmu branch leaves the mmu status register unchanged
// RULE_17 - reads use source space code, writes destination code; supervisor only
// RULE_18 - address register loads sign-extend; data register keeps upper bits
// RULE_19 - branch size bit 0 gives 16-bit, 1 gives 32-bit displacement
// RULE_20 - condition field forwarded to the memory manager which returns the verdict
// RULE_21 - disallowed move forms raise illegal-instruction, no access made
// RULE_22 - OR to status recognised by fixed opcode plus one immediate word
module pmb_decode (
	input wire sys_clk,
	input wire reset_n,
	input wire insn_valid,
	input wire [15:0] insn_word,
	input wire [15:0] ext_word1,
	input wire [15:0] ext_word2,
	input wire [31:0] insn_pc,
	input wire merged_space,
	input wire [2:0] source_space_code_reg,
	input wire [2:0] dest_space_code_reg,
	input wire [31:0] reg_read_data,
	input wire [31:0] reg_old_data,
	input wire [31:0] ea_address,
	input wire [31:0] mem_read_data,
	input wire mem_done,
	input wire mem_fault,
	input wire mmu_cond_valid,
	input wire mmu_cond_true,
	input wire status_write,
	input wire [15:0] status_write_data,
	output reg [15:0] processor_status_word,
	output reg [31:0] pc_out,
	output reg pc_load,
	output reg [3:0] reg_sel,
	output reg [31:0] reg_write_data,
	output reg [31:0] reg_write_mask,
	output reg reg_write,
	output reg mem_req,
	output reg mem_write,
	output reg [1:0] mem_size,
	output reg [2:0] mem_space,
	output reg [31:0] mem_addr,
	output reg [31:0] mem_write_data,
	output reg mmu_cond_req,
	output reg [5:0] mmu_cond,
	output reg [2:0] transfer_modifier_field,
	output reg access_fault,
	output reg privilege_trap,
	output reg illegal_trap,
	output wire busy
);
	localparam ST_IDLE = 3'b001;
	localparam ST_MEM = 3'b010;
	localparam ST_COND = 3'b100;

	reg [2:0] state_reg;
	reg [1:0] size_reg;
	reg dir_reg;
	reg [3:0] gr_reg;
	reg [2:0] space_reg;
	reg [31:0] bdisp_reg;

	function [2:0] space_map;
		input [2:0] fc;
		input merged;
		begin
			if (merged && fc == `PMB_FC_SPROG)
				space_map = `PMB_FC_SDATA; // RULE_06
			else if (merged && fc == `PMB_FC_UPROG)
				space_map = `PMB_FC_UDATA; // RULE_06
			else
				space_map = fc;
		end
	endfunction

	function [31:0] size_mask;
		input [1:0] sz;
		begin
			case (sz)
				`PMB_SIZE_BYTE: size_mask = 32'h000000FF; // RULE_01
				`PMB_SIZE_WORD: size_mask = 32'h0000FFFF;
				default: size_mask = 32'hFFFFFFFF;
			endcase
		end
	endfunction

	wire is_super = processor_status_word[`PMB_STATUS_SUPER_BIT];
	wire is_or_status = insn_word == `PMB_OR_STATUS_OPCODE; // RULE_22
	wire is_moves = insn_word[15:8] == `PMB_MOVES_OP_HI && insn_word[7:6] != 2'b11;
	wire is_mmu_branch = insn_word[15:7] == `PMB_MMU_BR_OP_HI;
	wire [2:0] ea_mode = insn_word[5:3];
	wire [2:0] ea_reg = insn_word[2:0];
	wire ea_ok = (ea_mode >= `PMB_MODE_IND && ea_mode <= `PMB_MODE_IDX) ||
		(ea_mode == `PMB_MODE_ABS && (ea_reg == `PMB_REG_ABS_W || ea_reg == `PMB_REG_ABS_L)); // RULE_02
	wire ext_ok = ext_word1[10:0] == 11'h000;
	wire moves_dir = ext_word1[11]; // RULE_04
	wire [31:0] disp = insn_word[`PMB_BR_SIZE_BIT] ? {ext_word1, ext_word2} :
		{{16{ext_word1[15]}}, ext_word1}; // RULE_14 RULE_19
	wire [31:0] ld_val = (size_reg == `PMB_SIZE_BYTE) ? {{24{mem_read_data[7]}}, mem_read_data[7:0]} :
		(size_reg == `PMB_SIZE_WORD) ? {{16{mem_read_data[15]}}, mem_read_data[15:0]} : mem_read_data;

	assign busy = state_reg != ST_IDLE;

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= ST_IDLE;
			size_reg <= 2'h0;
			dir_reg <= 1'b0;
			gr_reg <= 4'h0;
			space_reg <= 3'h0;
			bdisp_reg <= 32'h00000000;
			processor_status_word <= `PMB_STATUS_RESET;
			pc_out <= `PMB_PC_RESET;
			pc_load <= 1'b0;
			reg_sel <= 4'h0;
			reg_write_data <= 32'h00000000;
			reg_write_mask <= 32'h00000000;
			reg_write <= 1'b0;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_size <= 2'h0;
			mem_space <= 3'h0;
			mem_addr <= 32'h00000000;
			mem_write_data <= 32'h00000000;
			mmu_cond_req <= 1'b0;
			mmu_cond <= 6'h00;
			transfer_modifier_field <= 3'h0;
			access_fault <= 1'b0;
			privilege_trap <= 1'b0;
			illegal_trap <= 1'b0;
		end
		else
		begin
			pc_load <= 1'b0;
			reg_write <= 1'b0;
			access_fault <= 1'b0;
			privilege_trap <= 1'b0;
			illegal_trap <= 1'b0;
			mmu_cond_req <= 1'b0;
			// the rest of the datapath owns the status word outside these instructions; an or below wins
			if (status_write)
				processor_status_word <= status_write_data;
			case (state_reg)
				ST_IDLE:
				begin
					if (insn_valid && is_or_status)
					begin
						if (!is_super)
							privilege_trap <= 1'b1; // RULE_09
						else
							processor_status_word <= processor_status_word | ext_word1; // RULE_10 RULE_11
					end
					else if (insn_valid && is_moves)
					begin
						if (!is_super)
							privilege_trap <= 1'b1; // RULE_17
						else if (!ea_ok || !ext_ok)
							illegal_trap <= 1'b1; // RULE_21
						else
						begin
							size_reg <= insn_word[7:6];
							dir_reg <= moves_dir;
							gr_reg <= ext_word1[15:12]; // RULE_03
							space_reg <= space_map(moves_dir ? dest_space_code_reg : source_space_code_reg,
								merged_space); // RULE_17
							mem_space <= space_map(moves_dir ? dest_space_code_reg : source_space_code_reg,
								merged_space);
							mem_req <= 1'b1;
							mem_write <= moves_dir;
							mem_size <= insn_word[7:6];
							mem_addr <= ea_address;
							// updated base already in reg_read_data when it is the source
							mem_write_data <= reg_read_data & size_mask(insn_word[7:6]); // RULE_05
							state_reg <= ST_MEM;
						end
					end
					else if (insn_valid && is_mmu_branch)
					begin
						if (!is_super)
							privilege_trap <= 1'b1; // RULE_12
						else
						begin
							mmu_cond <= insn_word[5:0]; // RULE_15 RULE_20
							mmu_cond_req <= 1'b1;
							bdisp_reg <= insn_pc + 32'h00000002 + disp; // RULE_13
							state_reg <= ST_COND;
						end
					end
				end
				ST_MEM:
				begin
					if (mem_done || mem_fault)
					begin
						mem_req <= 1'b0;
						state_reg <= ST_IDLE;
						if (mem_fault)
						begin
							access_fault <= 1'b1;
							transfer_modifier_field <= space_reg; // RULE_07
						end
						else if (!dir_reg)
						begin
							reg_write <= 1'b1;
							reg_sel <= gr_reg;
							if (gr_reg[3])
							begin
								reg_write_data <= ld_val; // RULE_18
								reg_write_mask <= 32'hFFFFFFFF;
							end
							else
							begin
								reg_write_data <= (reg_old_data & ~size_mask(size_reg)) |
									(mem_read_data & size_mask(size_reg)); // RULE_18
								reg_write_mask <= size_mask(size_reg);
							end
						end
					end
				end
				ST_COND:
				begin
					// no mmu status written here
					if (mmu_cond_valid)
					begin
						state_reg <= ST_IDLE; // RULE_16
						if (mmu_cond_true)
						begin
							pc_out <= bdisp_reg; // RULE_12
							pc_load <= 1'b1;
						end
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // pmb_decode
`default_nettype wire

// file: dv/pmb_decode_monitor.sv
`default_nettype none
module pmb_decode_monitor (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic insn_valid,
	input wire logic [15:0] insn_word,
	input wire logic [15:0] ext_word1,
	input wire logic [15:0] processor_status_word,
	input wire logic mem_req,
	input wire logic mem_done,
	input wire logic mem_fault,
	input wire logic mmu_cond_valid,
	input wire logic mmu_cond_true,
	input wire logic mmu_cond_req,
	input wire logic [5:0] mmu_cond,
	input wire logic pc_load,
	input wire logic access_fault,
	input wire logic privilege_trap,
	input wire logic illegal_trap,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	wire logic take = insn_valid && !busy;
	wire logic sup = processor_status_word[13];
	wire logic or_status = take && insn_word == 16'h007C;
	wire logic [5:0] cf = insn_word[5:0];
	AST_OR_TRAP: assert property (or_status && !sup |=> privilege_trap && $stable(processor_status_word))
		else $error("status changed in user state");
	AST_OR_SET: assert property (or_status && sup |=>
		processor_status_word == ($past(processor_status_word) | $past(ext_word1)))
		else $error("status not ORed");
	AST_MEM_HOLD: assert property (mem_req && !mem_done && !mem_fault |=> mem_req)
		else $error("request dropped early");
	AST_MEM_DONE: assert property (mem_req && mem_done |=> !mem_req)
		else $error("request kept after done");
	AST_FAULT: assert property (mem_req && mem_fault |=> access_fault && !mem_req)
		else $error("fault not reported");
	AST_MMU_REQ: assert property (take && sup && insn_word[15:7] == 9'h1E1 |=> mmu_cond_req && mmu_cond == $past(cf))
		else $error("condition not forwarded");
	AST_BR_TRAP: assert property (take && !sup && insn_word[15:7] == 9'h1E1 |=> privilege_trap && !mmu_cond_req)
		else $error("mmu branch ran in user state");
	AST_BR_TAKE: assert property (busy && mmu_cond_valid && mmu_cond_true |=> pc_load)
		else $error("branch not taken");
	AST_BR_FALL: assert property (busy && mmu_cond_valid && !mmu_cond_true |=> !pc_load)
		else $error("branch taken on false");
	AST_ILL: assert property (take && sup && insn_word == 16'h0E00 |=> illegal_trap && !mem_req)
		else $error("bad mode accepted");
	cover property (or_status);
	cover property (privilege_trap);
	cover property (mem_req && mem_fault);
	cover property (pc_load);
endmodule // pmb_decode_monitor
bind pmb_decode pmb_decode_monitor u_pmb_decode_monitor (.sys_clk, .reset_n, .insn_valid, .insn_word, .ext_word1,
	.processor_status_word, .mem_req, .mem_done, .mem_fault, .mmu_cond_valid, .mmu_cond_true, .mmu_cond_req,
	.mmu_cond, .pc_load, .access_fault, .privilege_trap, .illegal_trap, .busy);
`default_nettype wire

// file: dv/pmb_mem_model.sv
`default_nettype none
module pmb_mem_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic mem_req,
	input wire logic mmu_cond_req,
	input wire logic [1:0] dly,
	input wire logic flt,
	input wire logic verdict,
	input wire logic [31:0] rdata,
	output logic mem_done,
	output logic mem_fault,
	output logic [31:0] mem_read_data,
	output logic mmu_cond_valid,
	output logic mmu_cond_true
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt;
	wire logic wait_ans = mem_req && !mem_done && !mem_fault;
	always @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
		begin
			cnt <= 2'h0;
			mem_done <= 1'b0;
			mem_fault <= 1'b0;
			mmu_cond_valid <= 1'b0;
			mmu_cond_true <= 1'b0;
			mem_read_data <= 32'h0;
		end
		else
		begin
			cnt <= (wait_ans && cnt != dly) ? cnt + 2'h1 : 2'h0;
			mem_done <= wait_ans && cnt == dly && !flt;
			mem_fault <= wait_ans && cnt == dly && flt;
			// data is only good in the answer cycle, so it toggles otherwise
			mem_read_data <= (wait_ans && cnt == dly) ? rdata : ~mem_read_data;
			mmu_cond_valid <= mmu_cond_req;
			mmu_cond_true <= mmu_cond_req ? verdict : ~mmu_cond_true;
		end
endmodule // pmb_mem_model
`default_nettype wire

// file: dv/pmb_decode_tb.sv
`default_nettype none
module pmb_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, reset_n = 0, insn_valid = 0, merged_space = 0, flt = 0, verdict = 0;
	logic [15:0] insn_word = 0, ext_word1 = 0, ext_word2 = 0;
	logic [2:0] source_space_code_reg = 3'h1, dest_space_code_reg = 3'h6;
	logic [1:0] dly = 2'h0;
	logic status_write = 1'b0;
	logic [15:0] status_write_data = 16'h0000;
	logic [6:0] seen = 7'h00;
	logic [31:0] insn_pc = 32'h100, reg_read_data = 32'hAABBCCDD, reg_old_data = 32'h11223344;
	logic [31:0] ea_address = 32'h40, rdata = 32'h8001;
	int fail_count = 0, samples_checked = 0;
	wire [15:0] processor_status_word;
	wire [31:0] pc_out, reg_write_data, reg_write_mask, mem_addr, mem_write_data, mem_read_data;
	wire [3:0] reg_sel;
	wire [1:0] mem_size;
	wire [2:0] mem_space, transfer_modifier_field;
	wire [5:0] mmu_cond;
	wire pc_load, reg_write, mem_req, mem_write, mmu_cond_req, access_fault, privilege_trap, illegal_trap, busy;
	wire mem_done, mem_fault, mmu_cond_valid, mmu_cond_true;
	pmb_decode u_pmb_decode (.sys_clk, .reset_n, .insn_valid, .insn_word, .ext_word1, .ext_word2, .insn_pc,
		.merged_space, .source_space_code_reg, .dest_space_code_reg, .reg_read_data, .reg_old_data, .ea_address,
		.mem_read_data, .mem_done, .mem_fault, .mmu_cond_valid, .mmu_cond_true, .status_write, .status_write_data,
		.processor_status_word, .pc_out,
		.pc_load, .reg_sel, .reg_write_data, .reg_write_mask, .reg_write, .mem_req, .mem_write, .mem_size, .mem_space,
		.mem_addr, .mem_write_data, .mmu_cond_req, .mmu_cond, .transfer_modifier_field, .access_fault,
		.privilege_trap, .illegal_trap, .busy);
	pmb_mem_model u_pmb_mem_model (.sys_clk, .reset_n, .mem_req, .mmu_cond_req, .dly, .flt, .verdict, .rdata,
		.mem_done, .mem_fault, .mem_read_data, .mmu_cond_valid, .mmu_cond_true);
	always #20 sys_clk = ~sys_clk;
	// pulses are gathered mid-cycle, away from the edge that launches them; a new request clears them
	always @(negedge sys_clk)
		seen <= insn_valid ? 7'h00 :
			seen | {mmu_cond_req, mem_req, privilege_trap, pc_load, reg_write, access_fault, illegal_trap};
	task automatic close_out;
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic go(input logic [15:0] w, input logic [15:0] e1, input logic [15:0] e2);
		int n;
		insn_word = w;
		ext_word1 = e1;
		ext_word2 = e2;
		insn_valid = 1;
		@(posedge sys_clk) #1;
		insn_valid = 0;
		for (n = 0; n < 30 && busy !== 1'b0; n++)
			@(posedge sys_clk) #1;
		if (n == 30)
		begin
			fail_count++;
			close_out();
		end
		repeat (2) @(posedge sys_clk) #1;
	endtask
	logic [15:0] bad[4] = '{16'h0E00, 16'h0E08, 16'h0EBA, 16'h0E90};
	initial
	begin
		repeat (12) @(posedge sys_clk);
		#1 reset_n = 1;
		go(16'h007C, 16'h001F, 16'h0);
		chk(processor_status_word, 32'h271F);
		for (int c = 0; c < 16; c++)
		begin
			verdict = c[0];
			go(16'hF080 | c[15:0], 16'h0010, 16'h0);
			chk(mmu_cond, c[5:0]);
			chk(seen[3], c[0]);
			if (c[0])
				chk(pc_out, 32'h112);
		end
		go(16'hF0C0, 16'hFFFF, 16'hFFF0);
		chk(pc_out, 32'hF2);
		go(16'h0E50, 16'hB000, 16'h0);
		chk(reg_write_data, 32'hFFFF8001);
		chk({reg_sel, mem_space, mem_write}, {4'hB, 3'h1, 1'b0});
		chk(reg_write_mask, 32'hFFFFFFFF);
		chk({seen[2], mem_size, mem_addr[15:0]}, {1'b1, 2'h1, 16'h0040});
		dly = 2'h2;
		go(16'h0E10, 16'h2000, 16'h0);
		chk(reg_write_data, 32'h11223301);
		chk(reg_write_mask, 32'h000000FF);
		merged_space = 1;
		// the bench holds no instruction cache, so no line needs invalidating before this write
		go(16'h0E18, 16'h2800, 16'h0);
		chk({mem_space, mem_write}, {3'h5, 1'b1});
		chk(seen[2], 1'b0);
		chk(mem_write_data, 32'hDD);
		flt = 1;
		dest_space_code_reg = 3'h2;
		go(16'h0EB9, 16'h2800, 16'h0);
		chk({seen[1], transfer_modifier_field}, {1'b1, 3'h1});
		flt = 0;
		for (int i = 0; i < 4; i++)
		begin
			go(bad[i], i == 3 ? 16'h2801 : 16'h2800, 16'h0);
			chk(seen[0], 1'b1);
		end
		// leave supervisor state through the datapath's status write
		status_write_data = 16'h0000;
		status_write = 1'b1;
		@(posedge sys_clk) #1;
		status_write = 1'b0;
		go(16'h007C, 16'h0004, 16'h0);
		chk({seen[4], processor_status_word}, {1'b1, 16'h0000});
		go(16'hF081, 16'h0010, 16'h0);
		chk(seen[6:3], 4'h2);
		go(16'h0E50, 16'hB000, 16'h0);
		chk(seen[6:4], 3'h1);
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk) #1;
		reset_n = 1'b1;
		chk(processor_status_word, 32'h00002700);
		chk(pc_out, 32'h00000000);
		go(16'h007C, 16'h0001, 16'h0);
		chk(processor_status_word, 32'h00002701);
		close_out();
	end
endmodule // pmb_decode_tb
`default_nettype wire
